//--- rtl/tcr_top.sv
/*
 * Paged calibration registers behind a host link, DAC connect control,
 * temperature and current calibration, temperature limits.
 * Assumes link_clk runs until the answer; channel inputs are on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - dac writes need on, rise done, mode 1x
// - mode write 10b hard connects held code
// - mode write 11b starts soft connection
// - after soft connect read returns found code
// - dac writes dropped in mode 00b, 01b
// - dac bits 15:10 read zero, 9:0 code
// - sense gain clamped 0.01 to 1000 milliohm
// - sense gain reads back last written value
// - current is dv over gain*factor plus offset
// - factor is 1+tc*1e-6*(t+heat-25)
// - factor clamped to 0.25 through 4.0
// - tempco is signed ppm per degree integer
// - each page uses its own diode temperature
// - temp is kelvin*gain-273.15+offset
// - invalid diode: die temperature used instead
// - diode gain unsigned, 0x4000 is unity
// - diode temp compared against four limits
// - self heat register is read only
// - mode 00b soft connects after rise time
module tcr_top
    import tcr_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 ce,
    input  wire logic                 link_clk,
    input  wire logic                 lk_req,
    input  wire logic                 lk_write,
    input  wire logic [7:0]           lk_cmd,
    input  wire logic [15:0]          lk_wdata,
    output var  logic                 lk_ack_ff,
    output var  logic [15:0]          lk_rdata_ff,
    output var  logic                 lk_err_ff,
    output var  logic                 lk_busy_ff,
    input  wire logic [NCH-1:0]       chan_on,
    input  wire logic [NCH-1:0]       rise_done,
    input  wire logic [NCH-1:0][1:0]  dac_mode,
    input  wire logic [NCH-1:0]       dac_mode_wr,
    input  wire logic [NCH-1:0]       soft_done,
    input  wire logic [NCH-1:0][9:0]  soft_code,
    input  wire logic [NCH-1:0]       ext_valid,
    input  wire logic [NCH-1:0][19:0] ext_kelvin_q8,
    input  wire logic [15:0]          die_temp_q8,
    input  wire logic [NCH-1:0][19:0] sense_uv,
    input  wire logic [NCH-1:0][15:0] self_heat_l11,
    output var  logic [NCH-1:0][9:0]  dac_code_ff,
    output var  logic [NCH-1:0]       dac_connect_ff,
    output var  logic [NCH-1:0]       dac_soft_req_ff,
    output var  logic [NCH-1:0][23:0] temp_q8_ff,
    output var  logic [NCH-1:0][19:0] tcorr_q16_ff,
    output var  logic [NCH-1:0][31:0] iout_ma_ff,
    output var  logic [NCH-1:0]       ot_fault_ff,
    output var  logic [NCH-1:0]       ot_warn_ff,
    output var  logic [NCH-1:0]       ut_warn_ff,
    output var  logic [NCH-1:0]       ut_fault_ff
);

    // link domain
    logic        req_tgl_ff, lk_write_ff;
    logic [7:0]  lk_cmd_ff;
    logic [15:0] lk_wdata_ff;
    logic        ack_s1_ff, ack_s2_ff, ack_s3_ff, ack_edge;

    logic        req_s1_ff, req_s2_ff, req_s3_ff;
    logic        ack_tgl_ff, page_ff;
    logic [16:0] ans_hold_ff;
    logic [15:0] regs_ff [NCH][TCR_NREG];
    logic [DAC_CODE_W-1:0] direct_ff [NCH];
    tcr_dac_st_type        dac_st_ff [NCH];
    tcr_dac_st_type        nxt_dac_st [NCH];

    logic        go, wr_go;
    logic [3:0]  cmd_idx;
    logic [NCH-1:0] dac_wr_ok;

    assign ack_edge = ack_s2_ff ^ ack_s3_ff;

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_tgl_ff  <= 1'b0;
            lk_write_ff <= 1'b0;
            lk_cmd_ff   <= 8'h00;
            lk_wdata_ff <= 16'h0000;
            lk_busy_ff  <= 1'b0;
        end else if (lk_req && !lk_busy_ff) begin
            // fields stay frozen until the answer returns
            req_tgl_ff  <= ~req_tgl_ff;
            lk_write_ff <= lk_write;
            lk_cmd_ff   <= lk_cmd;
            lk_wdata_ff <= lk_wdata;
            lk_busy_ff  <= 1'b1;
        end else if (ack_edge) begin
            lk_busy_ff  <= 1'b0;
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_s1_ff   <= 1'b0;
            ack_s2_ff   <= 1'b0;
            ack_s3_ff   <= 1'b0;
            lk_ack_ff   <= 1'b0;
            lk_rdata_ff <= 16'h0000;
            lk_err_ff   <= 1'b0;
        end else begin
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            ack_s3_ff <= ack_s2_ff;
            lk_ack_ff <= ack_edge;
            if (ack_edge) begin
                lk_rdata_ff <= ans_hold_ff[15:0];
                lk_err_ff   <= ans_hold_ff[16];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
        end else if (ce) begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
        end
    end

    // the captured fields are only read once the toggle has settled
    assign go      = ce && (req_s2_ff ^ req_s3_ff);
    assign wr_go   = go && lk_write_ff;
    assign cmd_idx = tcr_decode(lk_cmd_ff);

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            dac_wr_ok[c] = wr_go && (lk_cmd_ff == CMD_DAC)
                && (page_ff == c[0]) && chan_on[c] && rise_done[c]
                && dac_mode[c][1];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            page_ff <= RST_PAGE[0];
        end else if (wr_go && lk_cmd_ff == CMD_PAGE
                     && lk_wdata_ff[15:1] == 15'h0000) begin
            page_ff <= lk_wdata_ff[0];
        end
    end

    // gain is stored raw; clamping happens only in the datapath
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                for (int r = 0; r < TCR_NREG; r++) begin
                    regs_ff[c][r] <= RST_VAL[r];
                end
            end
        end else if (wr_go && cmd_idx != IDX_NONE) begin
            regs_ff[page_ff][cmd_idx] <= lk_wdata_ff;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_tgl_ff  <= 1'b0;
            ans_hold_ff <= 17'h00000;
        end else if (go) begin
            ack_tgl_ff <= ~ack_tgl_ff;
            case (lk_cmd_ff)
                CMD_PAGE: begin
                    ans_hold_ff <= {lk_write_ff && lk_wdata_ff[15:1] != 15'h0000,
                                    15'h0000, page_ff};
                end
                CMD_DAC: begin
                    ans_hold_ff <= {1'b0, 6'h00, direct_ff[page_ff]};
                end
                CMD_SELF_HEAT: begin
                    // writes refused, reads report the live value
                    ans_hold_ff <= {lk_write_ff,
                                    self_heat_l11[page_ff]};
                end
                default: begin
                    if (cmd_idx != IDX_NONE) begin
                        ans_hold_ff <= {1'b0, regs_ff[page_ff][cmd_idx]};
                    end else begin
                        ans_hold_ff <= {1'b1, 16'h0000};
                    end
                end
            endcase
        end
    end

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            nxt_dac_st[c] = dac_st_ff[c];
            if (!chan_on[c]) begin
                nxt_dac_st[c] = DAC_OFF;
            end else if (dac_mode_wr[c] && rise_done[c]
                         && dac_mode[c] == MODE_HARD) begin
                nxt_dac_st[c] = DAC_HARD;
            end else if (dac_mode_wr[c] && rise_done[c]
                         && dac_mode[c] == MODE_SOFT) begin
                nxt_dac_st[c] = DAC_SOFT;
            end else begin
                case (dac_st_ff[c])
                    DAC_OFF: begin
                        if (rise_done[c] && (dac_mode[c] == MODE_RISE_SOFT
                                || dac_mode[c] == MODE_SOFT)) begin
                            nxt_dac_st[c] = DAC_SOFT;
                        end else if (rise_done[c]
                                     && dac_mode[c] == MODE_HARD) begin
                            nxt_dac_st[c] = DAC_HARD;
                        end
                    end
                    DAC_SOFT: begin
                        if (soft_done[c]) begin
                            nxt_dac_st[c] = DAC_SOFTED;
                        end
                    end
                    DAC_HARD: nxt_dac_st[c] = DAC_HARD;
                    DAC_SOFTED: nxt_dac_st[c] = DAC_SOFTED;
                    default: nxt_dac_st[c] = DAC_OFF;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                dac_st_ff[c] <= DAC_OFF;
            end
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                dac_st_ff[c] <= nxt_dac_st[c];
            end
        end
    end

    // the soft search result overrides a host write in the same cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < NCH; c++) begin
                direct_ff[c] <= RST_DAC_CODE;
            end
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                if (dac_st_ff[c] == DAC_SOFT && soft_done[c]) begin
                    direct_ff[c] <= soft_code[c];
                end else if (dac_wr_ok[c]) begin
                    direct_ff[c] <= lk_wdata_ff[DAC_CODE_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dac_code_ff     <= '0;
            dac_connect_ff  <= '0;
            dac_soft_req_ff <= '0;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                dac_connect_ff[c]  <= nxt_dac_st[c] == DAC_HARD
                                   || nxt_dac_st[c] == DAC_SOFTED;
                dac_soft_req_ff[c] <= nxt_dac_st[c] == DAC_SOFT;
                if (dac_st_ff[c] == DAC_HARD
                        || dac_st_ff[c] == DAC_SOFTED) begin
                    dac_code_ff[c] <= direct_ff[c];
                end
            end
        end
    end

    tcr_wide_type nxt_temp [NCH], nxt_tcorr [NCH], nxt_iout [NCH];

    always_comb begin
        tcr_wide_type gain;
        tcr_wide_type dtemp;
        gain  = '0;
        dtemp = '0;
        for (int c = 0; c < NCH; c++) begin
            if (ext_valid[c]) begin
                nxt_temp[c] = ((tcr_wide_type'(ext_kelvin_q8[c])
                    * tcr_wide_type'(regs_ff[c][IDX_DIODE_GAIN]))
                    >>> DIODE_FRAC) - KELVIN_OFS_Q8
                    + tcr_l11(regs_ff[c][IDX_DIODE_OFS]);
            end else begin
                nxt_temp[c] = tcr_wide_type'(signed'(die_temp_q8));
            end
            dtemp = tcr_wide_type'(signed'(temp_q8_ff[c]))
                  + tcr_l11(self_heat_l11[c]) - REF_TEMP_Q8;
            nxt_tcorr[c] = UNITY_Q16
                + (tcr_wide_type'(signed'(regs_ff[c][IDX_TEMPCO]))
                   * dtemp * 64'sh100) / PPM_DIV;
            if (nxt_tcorr[c] < TCORR_MIN_Q16) begin
                nxt_tcorr[c] = TCORR_MIN_Q16;
            end else if (nxt_tcorr[c] > TCORR_MAX_Q16) begin
                nxt_tcorr[c] = TCORR_MAX_Q16;
            end
            gain = tcr_l11(regs_ff[c][IDX_GAIN]);
            if (gain < GAIN_MIN_Q8) begin
                gain = GAIN_MIN_Q8;
            end else if (gain > GAIN_MAX_Q8) begin
                gain = GAIN_MAX_Q8;
            end
            nxt_iout[c] = ((tcr_wide_type'(signed'(sense_uv[c])) <<< CUR_SHIFT)
                / (gain * tcr_wide_type'(tcorr_q16_ff[c])))
                + ((tcr_l11(regs_ff[c][IDX_OFFSET]) * MILLI_MUL)
                   >>> 8);
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            temp_q8_ff   <= '0;
            tcorr_q16_ff <= {NCH{UNITY_Q16[19:0]}};
            iout_ma_ff   <= '0;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                temp_q8_ff[c]   <= nxt_temp[c][23:0];
                tcorr_q16_ff[c] <= nxt_tcorr[c][19:0];
                iout_ma_ff[c]   <= nxt_iout[c][31:0];
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ot_fault_ff <= '0;
            ot_warn_ff  <= '0;
            ut_warn_ff  <= '0;
            ut_fault_ff <= '0;
        end else if (ce) begin
            for (int c = 0; c < NCH; c++) begin
                ot_fault_ff[c] <= nxt_temp[c]
                    > tcr_l11(regs_ff[c][IDX_OT_FAULT]);
                ot_warn_ff[c]  <= nxt_temp[c]
                    > tcr_l11(regs_ff[c][IDX_OT_WARN]);
                ut_warn_ff[c]  <= nxt_temp[c]
                    < tcr_l11(regs_ff[c][IDX_UT_WARN]);
                ut_fault_ff[c] <= nxt_temp[c]
                    < tcr_l11(regs_ff[c][IDX_UT_FAULT]);
            end
        end
    end

endmodule : tcr_top

`default_nettype wire

//--- rtl/tcr_pkg.sv
/*
 * Calibration register constants: command codes, indices, reset values,
 * fixed point scaling, DAC states.
 * Assumes two pages, PMBus style command codes.
 */
package tcr_pkg;

    // command codes
    localparam logic [7:0] CMD_PAGE        = 8'h00;
    localparam logic [7:0] CMD_SENSE_GAIN  = 8'h38;
    localparam logic [7:0] CMD_CUR_OFFSET  = 8'h39;
    localparam logic [7:0] CMD_OC_WARN     = 8'h4A;
    localparam logic [7:0] CMD_OT_FAULT    = 8'h4F;
    localparam logic [7:0] CMD_OT_WARN     = 8'h51;
    localparam logic [7:0] CMD_UT_WARN     = 8'h52;
    localparam logic [7:0] CMD_UT_FAULT    = 8'h53;
    localparam logic [7:0] CMD_SELF_HEAT   = 8'hB8;
    localparam logic [7:0] CMD_TAU_INV     = 8'hB9;
    localparam logic [7:0] CMD_THETA       = 8'hBA;
    localparam logic [7:0] CMD_DAC         = 8'hE0;
    localparam logic [7:0] CMD_TEMPCO      = 8'hF6;
    localparam logic [7:0] CMD_DIODE_GAIN  = 8'hF8;
    localparam logic [7:0] CMD_DIODE_OFS   = 8'hF9;

    // paged storage indices
    localparam int         TCR_NREG        = 12;
    localparam logic [3:0] IDX_GAIN        = 4'h0;
    localparam logic [3:0] IDX_OFFSET      = 4'h1;
    localparam logic [3:0] IDX_OC_WARN     = 4'h2;
    localparam logic [3:0] IDX_OT_FAULT    = 4'h3;
    localparam logic [3:0] IDX_OT_WARN     = 4'h4;
    localparam logic [3:0] IDX_UT_WARN     = 4'h5;
    localparam logic [3:0] IDX_UT_FAULT    = 4'h6;
    localparam logic [3:0] IDX_TAU_INV     = 4'h7;
    localparam logic [3:0] IDX_THETA       = 4'h8;
    localparam logic [3:0] IDX_TEMPCO      = 4'h9;
    localparam logic [3:0] IDX_DIODE_GAIN  = 4'hA;
    localparam logic [3:0] IDX_DIODE_OFS   = 4'hB;
    localparam logic [3:0] IDX_NONE        = 4'hF;

    localparam logic [15:0] RST_VAL [TCR_NREG] = '{
        16'hBA00, 16'h8000, 16'hCA80, 16'hEA08, 16'hE3C0, 16'h8000,
        16'hCD80, 16'h8000, 16'h8000, 16'h0000, 16'h4000, 16'h8000};
    localparam logic [15:0] RST_PAGE       = 16'h0000;
    localparam logic [9:0]  RST_DAC_CODE   = 10'h000;

    // DAC code width, connect modes
    localparam int         DAC_CODE_W      = 10;
    localparam logic [1:0] MODE_RISE_SOFT  = 2'h0;
    localparam logic [1:0] MODE_HARD       = 2'h2;
    localparam logic [1:0] MODE_SOFT       = 2'h3;

    // fixed point: values in 1/256, factor in 1/65536
    typedef logic signed [63:0] tcr_wide_type;
    localparam tcr_wide_type GAIN_MIN_Q8   = 64'sh3;
    localparam tcr_wide_type GAIN_MAX_Q8   = 64'sh3E800;
    localparam tcr_wide_type KELVIN_OFS_Q8 = 64'sh11126;
    localparam tcr_wide_type REF_TEMP_Q8   = 64'sh1900;
    localparam tcr_wide_type UNITY_Q16     = 64'sh10000;
    localparam tcr_wide_type TCORR_MIN_Q16 = 64'sh4000;
    localparam tcr_wide_type TCORR_MAX_Q16 = 64'sh40000;
    localparam tcr_wide_type PPM_DIV       = 64'shF4240;
    localparam tcr_wide_type MILLI_MUL     = 64'sh3E8;
    localparam int           DIODE_FRAC    = 14;
    localparam int           CUR_SHIFT     = 24;

    typedef enum logic [3:0] {
        DAC_OFF    = 4'h1,
        DAC_SOFT   = 4'h2,
        DAC_HARD   = 4'h4,
        DAC_SOFTED = 4'h8
    } tcr_dac_st_type;

    // linear-11 word to signed 1/256 fixed point
    function automatic tcr_wide_type tcr_l11(input logic [15:0] v);
        tcr_wide_type    m;
        logic signed [5:0] e;
        m = tcr_wide_type'(signed'(v[10:0]));
        e = signed'({v[15], v[15:11]}) + 6'sh08;
        if (e >= 6'sh00) begin
            tcr_l11 = m <<< e;
        end else begin
            tcr_l11 = m >>> (-e);
        end
    endfunction : tcr_l11

    function automatic logic [3:0] tcr_decode(input logic [7:0] cmd);
        case (cmd)
            CMD_SENSE_GAIN: tcr_decode = IDX_GAIN;
            CMD_CUR_OFFSET: tcr_decode = IDX_OFFSET;
            CMD_OC_WARN:    tcr_decode = IDX_OC_WARN;
            CMD_OT_FAULT:   tcr_decode = IDX_OT_FAULT;
            CMD_OT_WARN:    tcr_decode = IDX_OT_WARN;
            CMD_UT_WARN:    tcr_decode = IDX_UT_WARN;
            CMD_UT_FAULT:   tcr_decode = IDX_UT_FAULT;
            CMD_TAU_INV:    tcr_decode = IDX_TAU_INV;
            CMD_THETA:      tcr_decode = IDX_THETA;
            CMD_TEMPCO:     tcr_decode = IDX_TEMPCO;
            CMD_DIODE_GAIN: tcr_decode = IDX_DIODE_GAIN;
            CMD_DIODE_OFS:  tcr_decode = IDX_DIODE_OFS;
            default:        tcr_decode = IDX_NONE;
        endcase
    endfunction : tcr_decode

endpackage : tcr_pkg

//--- tb/tcr_top_sva.sv
/* mclk-domain port checks of tcr_top
   bound into every tcr_top, sees only its ports */
`timescale 1ns/1ps
`default_nettype none
module tcr_top_sva
    import tcr_pkg::*;
#(parameter int NCH = 2) (
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire logic                 ce,
    input wire logic [NCH-1:0]       chan_on,
    input wire logic [NCH-1:0]       rise_done,
    input wire logic [NCH-1:0][1:0]  dac_mode,
    input wire logic [NCH-1:0]       dac_mode_wr,
    input wire logic [NCH-1:0]       soft_done,
    input wire logic [NCH-1:0]       ext_valid,
    input wire logic [15:0]          die_temp_q8,
    input wire logic [NCH-1:0]       dac_connect_ff,
    input wire logic [NCH-1:0]       dac_soft_req_ff,
    input wire logic [NCH-1:0][23:0] temp_q8_ff,
    input wire logic [NCH-1:0][19:0] tcorr_q16_ff
);
    // off: neither connected nor searching
    wire logic off0 = !dac_connect_ff[0] && !dac_soft_req_ff[0];
    wire logic off1 = !dac_connect_ff[NCH-1] && !dac_soft_req_ff[NCH-1];
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chan_off_a:
        assert property (ce && !chan_on[0] |=> off0)
        else $error("dac on, channel off");
    not_risen_a:
        assert property (ce && dac_mode_wr[0] && !rise_done[0] && off0
        |=> off0) else $error("dac on before rise");
    hard_connect_a:
        assert property (ce && dac_mode_wr[0] && dac_mode[0] == MODE_HARD
        && chan_on[0] && rise_done[0] |=> dac_connect_ff[0])
        else $error("no hard connect");
    soft_start_a:
        assert property (ce && dac_mode_wr[0] && dac_mode[0] == MODE_SOFT
        && chan_on[0] && rise_done[0] && !soft_done[0]
        |=> dac_soft_req_ff[0]) else $error("no soft search");
    soft_finish_a:
        assert property (ce && chan_on[0] && dac_soft_req_ff[0]
        && soft_done[0] && !dac_mode_wr[0]
        |=> dac_connect_ff[0] && !dac_soft_req_ff[0])
        else $error("soft search hung");
    rise_soft_a:
        assert property (ce && chan_on[NCH-1] && rise_done[NCH-1] && off1
        && dac_mode[NCH-1] == MODE_RISE_SOFT |=> dac_soft_req_ff[NCH-1])
        else $error("no soft after rise");
    tcorr_range_a:
        assert property (tcorr_q16_ff[0] >= 20'h04000
        && tcorr_q16_ff[0] <= 20'h40000) else $error("factor range");
    die_subst_a:
        assert property (ce && !ext_valid[0] |=> temp_q8_ff[0] ==
        {{8{$past(die_temp_q8[15])}}, $past(die_temp_q8)})
        else $error("die temp unused");
endmodule : tcr_top_sva
bind tcr_top tcr_top_sva #(.NCH(NCH)) u_sva (.mclk, .sys_rst, .ce,
    .chan_on, .rise_done, .dac_mode, .dac_mode_wr, .soft_done, .ext_valid,
    .die_temp_q8, .dac_connect_ff, .dac_soft_req_ff, .temp_q8_ff,
    .tcorr_q16_ff);
`default_nettype wire

//--- tb/tcr_host.sv
/* host model on the command link, makes link_clk
   assumes one xfer call at a time */
`timescale 1ns/1ps
`default_nettype none
module tcr_host (
    output var  logic        link_clk,
    output var  logic        lk_req,
    output var  logic        lk_write,
    output var  logic [7:0]  lk_cmd,
    output var  logic [15:0] lk_wdata,
    input  wire logic        lk_ack_ff,
    input  wire logic        lk_busy_ff,
    input  wire logic [15:0] lk_rdata_ff,
    input  wire logic        lk_err_ff
);
    logic run = 1'b1;
    initial begin
        {link_clk, lk_req, lk_write, lk_cmd, lk_wdata} = '0;
        #7;
        // clock parks low between exchanges, runs through reset
        forever begin
            #24;
            if (run || link_clk) link_clk = ~link_clk;
        end
    end
    task automatic xfer(input logic wr, input logic [7:0] cmd,
        input logic [15:0] wd, output logic [15:0] rd, output logic er);
        int n;
        run = 1'b1;
        repeat (2) @(posedge link_clk);
        lk_req   <= 1'b1;
        lk_write <= wr;
        lk_cmd   <= cmd;
        lk_wdata <= wd;
        @(posedge link_clk);
        lk_req   <= 1'b0;
        // released lines stop showing the request
        lk_cmd   <= ~cmd;
        lk_wdata <= ~wd;
        n = 0;
        do begin
            @(negedge link_clk);
            n++;
        end while (lk_ack_ff !== 1'b1 && n < 100);
        rd = lk_rdata_ff;
        er = (n < 100) ? lk_err_ff : 1'bx;
        while (lk_busy_ff !== 1'b0 && n < 200) begin
            @(negedge link_clk);
            n++;
        end
        @(posedge link_clk);
        run = 1'b0;
    endtask : xfer
endmodule : tcr_host
`default_nettype wire

//--- tb/tcr_top_tb_top.sv
/* self-checking bench of tcr_top over its command link
   assumes tcr_host drives the link */
`timescale 1ns/1ps
`default_nettype none
module tcr_top_tb_top
    import tcr_pkg::*;
;
    logic mclk, sys_rst, ce, link_clk, lk_req, lk_write, er;
    logic lk_ack_ff, lk_err_ff, lk_busy_ff;
    logic [7:0] lk_cmd;
    logic [15:0] lk_wdata, lk_rdata_ff, die_temp_q8, rd;
    logic [1:0] chan_on, rise_done, dac_mode_wr, soft_done, ext_valid;
    logic [1:0] dac_connect_ff, dac_soft_req_ff, ot_fault_ff, ot_warn_ff;
    logic [1:0] ut_warn_ff, ut_fault_ff;
    logic [1:0][1:0] dac_mode;
    logic [1:0][9:0] soft_code, dac_code_ff;
    logic [1:0][19:0] ext_kelvin_q8, sense_uv, tcorr_q16_ff;
    logic [1:0][15:0] self_heat_l11;
    logic [1:0][23:0] temp_q8_ff;
    logic [1:0][31:0] iout_ma_ff;
    int err_total = 0, check_count = 0, cyc_n = 0;
    logic [7:0] cmds [TCR_NREG] = '{8'h38, 8'h39, 8'h4A, 8'h4F, 8'h51,
        8'h52, 8'h53, 8'hB9, 8'hBA, 8'hF6, 8'hF8, 8'hF9};
    tcr_host host (.link_clk, .lk_req, .lk_write, .lk_cmd, .lk_wdata,
        .lk_ack_ff, .lk_busy_ff, .lk_rdata_ff, .lk_err_ff);
    tcr_top #(.NCH(2)) dut (.mclk, .sys_rst, .ce, .link_clk, .lk_req,
        .lk_write, .lk_cmd, .lk_wdata, .lk_ack_ff, .lk_rdata_ff, .lk_err_ff,
        .lk_busy_ff, .chan_on, .rise_done, .dac_mode, .dac_mode_wr,
        .soft_done, .soft_code, .ext_valid, .ext_kelvin_q8, .die_temp_q8,
        .sense_uv, .self_heat_l11, .dac_code_ff, .dac_connect_ff,
        .dac_soft_req_ff, .temp_q8_ff, .tcorr_q16_ff, .iout_ma_ff,
        .ot_fault_ff, .ot_warn_ff, .ut_warn_ff, .ut_fault_ff);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge mclk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      input logic e);
        host.xfer(1'b1, c, d, rd, er);
        chk("wr err", e, er);
    endtask : wr
    task automatic rdc(input logic [7:0] c, input logic [15:0] x,
                       input logic e);
        host.xfer(1'b0, c, 16'h0000, rd, er);
        chk("rd data", x, rd);
        chk("rd err", e, er);
    endtask : rdc
    // datapath settles within its three-stage pipeline
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic pulse(ref logic [1:0] s);
        s = 2'b01;
        cyc(1);
        s = 2'b00;
    endtask : pulse
    initial begin
        sys_rst = 1'b1;
        {chan_on, rise_done, dac_mode, dac_mode_wr, soft_done} = '0;
        {soft_code, die_temp_q8, self_heat_l11} = '0;
        ce = 1'b1;
        ext_valid = 2'b11;
        ext_kelvin_q8 = {20'h12A26, 20'h12A26};
        sense_uv = {20'h01388, 20'h01388};
        cyc(4);
        sys_rst = 1'b0;
        for (int i = 0; i < TCR_NREG; i++) rdc(cmds[i], RST_VAL[i], 1'b0);
        cyc(5);
        chk("temp0", 32'h00001900, temp_q8_ff[0]);
        chk("tcorr0", 32'h00010000, tcorr_q16_ff[0]);
        chk("iout0", 32'h00001388, iout_ma_ff[0]);
        wr(8'h38, 16'h0BE8, 1'b0);
        cyc(5);
        chk("iout0 clamp", 32'h00000005, iout_ma_ff[0]);
        rdc(8'h38, 16'h0BE8, 1'b0);
        ext_kelvin_q8[0] = 20'h18E26;
        wr(8'hF6, 16'h7FFF, 1'b0);
        cyc(5);
        chk("temp0 hot", 32'h00007D00, temp_q8_ff[0]);
        chk("tcorr0 hi", 32'h00040000, tcorr_q16_ff[0]);
        chk("ot0", 32'h3, {ot_fault_ff[0], ot_warn_ff[0]});
        wr(8'hF6, 16'h8000, 1'b0);
        cyc(5);
        chk("tcorr0 lo", 32'h00004000, tcorr_q16_ff[0]);
        wr(8'h00, 16'h0001, 1'b0);
        wr(8'hF6, 16'h0F3C, 1'b0);
        rdc(8'hF6, 16'h0F3C, 1'b0);
        cyc(5);
        chk("tcorr1", 32'h00010000, tcorr_q16_ff[1]);
        chk("temp1", 32'h00001900, temp_q8_ff[1]);
        wr(8'h00, 16'h0000, 1'b0);
        rdc(8'hF6, 16'h8000, 1'b0);
        wr(8'hF8, 16'h8000, 1'b0);
        ext_kelvin_q8[0] = 20'h12A26;
        cyc(5);
        chk("temp0 g2", 32'h00014326, temp_q8_ff[0]);
        wr(8'hF8, 16'h4000, 1'b0);
        ext_kelvin_q8[0] = 20'h10726;
        cyc(5);
        chk("limits0", 32'hC, {ut_fault_ff[0], ut_warn_ff[0],
            ot_fault_ff[0], ot_warn_ff[0]});
        ext_valid[0] = 1'b0;
        die_temp_q8 = 16'hF600;
        cyc(5);
        chk("temp0 die", 32'h00FFF600, temp_q8_ff[0]);
        ext_valid[0] = 1'b1;
        wr(8'hB8, 16'h1234, 1'b1);
        rdc(8'h77, 16'h0000, 1'b1);
        wr(8'h00, 16'h0002, 1'b1);
        chan_on[0] = 1'b1;
        dac_mode[0] = MODE_HARD;
        pulse(dac_mode_wr);
        wr(8'hE0, 16'h1234, 1'b0);
        rdc(8'hE0, 16'h0000, 1'b0);
        dac_mode[0] = 2'h1;
        rise_done[0] = 1'b1;
        wr(8'hE0, 16'h1234, 1'b0);
        rdc(8'hE0, 16'h0000, 1'b0);
        dac_mode[0] = MODE_HARD;
        wr(8'hE0, 16'hFC55, 1'b0);
        rdc(8'hE0, 16'h0055, 1'b0);
        pulse(dac_mode_wr);
        cyc(2);
        chk("code hard", 32'h055, dac_code_ff[0]);
        chk("conn hard", 32'h1, dac_connect_ff[0]);
        dac_mode[0] = MODE_SOFT;
        pulse(dac_mode_wr);
        chk("soft req", 32'h1, dac_soft_req_ff[0]);
        soft_code[0] = 10'h2AA;
        pulse(soft_done);
        cyc(2);
        chk("conn soft", 32'h1, dac_connect_ff[0]);
        rdc(8'hE0, 16'h02AA, 1'b0);
        {chan_on[1], rise_done[1]} = 2'b11;
        cyc(3);
        chk("rise soft", 32'h1, dac_soft_req_ff[1]);
        tally_and_finish();
    end
endmodule : tcr_top_tb_top
`default_nettype wire
